// *** rtl/mote_uart_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module mote_uart_end import uart_link_pkg::*; #(
	parameter int BIT_CYC = BIT_CYC_FAST,
	parameter int RTS_WAIT_CYC = RTS_TIMEOUT_CYC,
	parameter int RETRY_CYC = RETRY_TIME_CYC,
	parameter int ANSWER_LIMIT_CYC = ANSWER_CYC,
	parameter int INTERBYTE_LIMIT_CYC = INTERBYTE_CYC,
	parameter int GAP_CYC = PACKET_GAP_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	uart_link_if.device link,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_stop_err,
	input wire logic net_joined,
	input wire logic buf_free,
	output logic answer_late,
	output logic ack_timeout
);
	// Pin synchronisers, first stage read only by the second
	logic cts_meta_reg, cts_sync_reg;
	logic rxd_meta_reg, rxd_sync_reg;
	// Sender state
	mote_tx_state_t tx_state_reg;
	logic [31:0] tx_timer_reg;      // Shared phase timer
	logic [31:0] since_start_reg;   // Time since the current start bit
	logic [8:0] tx_shift_reg;       // Data then stop bit
	logic [3:0] tx_bit_reg;
	logic tx_last_reg;
	logic ack_seen_reg;             // Clear went high after this byte's start bit
	logic txd_reg, rts_n_reg, pclear_n_reg;
	logic tx_ready_reg, ack_timeout_reg;
	// Receiver state
	logic rx_busy_reg;
	logic [31:0] rx_cnt_reg;
	logic [3:0] rx_bit_reg;
	logic [7:0] rx_shift_reg, rx_data_reg;
	logic rx_valid_reg, rx_stop_err_reg;
	// Request watchdog
	logic in_frame_reg, armed_reg, answer_late_reg;
	logic [31:0] answer_cnt_reg;
	logic cts_on;
	logic packet_begin;

	assign cts_on = !cts_sync_reg;
	// A packet starts leaving the idle state
	assign packet_begin = (tx_state_reg == MT_IDLE) && tx_valid;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cts_meta_reg <= 1'b1;
			cts_sync_reg <= 1'b1;
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
		end else begin
			cts_meta_reg <= link.host_clear_to_send_n;
			cts_sync_reg <= cts_meta_reg;
			rxd_meta_reg <= link.host_txd;
			rxd_sync_reg <= rxd_meta_reg;
		end
	end

	// packet clear follows join and buffer state
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pclear_n_reg <= 1'b1;
		end else begin
			pclear_n_reg <= !(net_joined && buf_free);
		end
	end

	// Time since start bit, feeds the acknowledge timeout
	always_ff @(posedge clk_sys) begin
		if (srst || tx_state_reg == MT_LOAD) begin
			since_start_reg <= '0;
		end else if (since_start_reg != 32'hffffffff) begin
			since_start_reg <= since_start_reg + 32'h1;
		end
	end

	// Sender: request, retry, byte shift and acknowledge wait
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_state_reg <= MT_IDLE;
			tx_timer_reg <= '0;
			tx_shift_reg <= '0;
			tx_bit_reg <= '0;
			tx_last_reg <= 1'b0;
			ack_seen_reg <= 1'b0;
			txd_reg <= 1'b1;
			rts_n_reg <= 1'b1;
			tx_ready_reg <= 1'b0;
			ack_timeout_reg <= 1'b0;
		end else begin
			tx_ready_reg <= 1'b0;
			unique case (tx_state_reg)
				MT_IDLE: begin
					// request as soon as a packet waits
					if (tx_valid) begin
						rts_n_reg <= 1'b0;
						tx_timer_reg <= '0;
						ack_timeout_reg <= 1'b0;
						tx_state_reg <= MT_REQ;
					end
				end
				MT_REQ: begin
					if (cts_on) begin
						// request drops the cycle after clear is seen
						rts_n_reg <= 1'b1;
						tx_state_reg <= MT_LOAD;
					end else if (tx_timer_reg == 32'(RTS_WAIT_CYC - 1)) begin
						// host missed its window, back off
						rts_n_reg <= 1'b1;
						tx_timer_reg <= '0;
						tx_state_reg <= MT_RETRY;
					end else begin
						tx_timer_reg <= tx_timer_reg + 32'h1;
					end
				end
				MT_RETRY: begin
					if (tx_timer_reg == 32'(RETRY_CYC - 1)) begin
						rts_n_reg <= 1'b0;
						tx_timer_reg <= '0;
						tx_state_reg <= MT_REQ;
					end else begin
						tx_timer_reg <= tx_timer_reg + 32'h1;
					end
				end
				MT_LOAD: begin
					// start bit goes out at once while clear holds
					if (tx_valid && cts_on) begin
						txd_reg <= 1'b0;
						tx_shift_reg <= {1'b1, tx_data};
						tx_last_reg <= tx_last;
						tx_ready_reg <= 1'b1;
						tx_bit_reg <= '0;
						tx_timer_reg <= '0;
						ack_seen_reg <= 1'b0;
						tx_state_reg <= MT_SHIFT;
					end
				end
				MT_SHIFT: begin
					// clear may drop once the start bit is past
					if (tx_bit_reg != 4'h0 && !cts_on) begin
						ack_seen_reg <= 1'b1;
					end
					if (tx_timer_reg == 32'(BIT_CYC - 1)) begin
						tx_timer_reg <= '0;
						// one full stop bit before moving on
						if (tx_bit_reg == 4'(STOP_INDEX)) begin
							tx_state_reg <= tx_last_reg ? MT_GAP : MT_ACK;
						end else begin
							txd_reg <= tx_shift_reg[0];
							tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
							tx_bit_reg <= tx_bit_reg + 4'h1;
						end
					end else begin
						tx_timer_reg <= tx_timer_reg + 32'h1;
					end
				end
				MT_ACK: begin
					// wait for negation, then for reassertion
					if (!ack_seen_reg) begin
						if (!cts_on) begin
							ack_seen_reg <= 1'b1;
						end else if (since_start_reg >= 32'(INTERBYTE_LIMIT_CYC)) begin
							// host never acknowledged, give the packet up
							ack_timeout_reg <= 1'b1;
							tx_timer_reg <= '0;
							tx_state_reg <= MT_GAP;
						end
					end else if (cts_on) begin
						tx_state_reg <= MT_LOAD;
					end
				end
				MT_GAP: begin
					if (tx_timer_reg == 32'(GAP_CYC - 1)) begin
						tx_timer_reg <= '0;
						tx_state_reg <= MT_IDLE;
					end else begin
						tx_timer_reg <= tx_timer_reg + 32'h1;
					end
				end
			endcase
		end
	end

	// Receiver; sampling at mid-bit tolerates the host's 2% skew
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_busy_reg <= 1'b0;
			rx_cnt_reg <= '0;
			rx_bit_reg <= '0;
			rx_shift_reg <= '0;
			rx_data_reg <= '0;
			rx_valid_reg <= 1'b0;
			rx_stop_err_reg <= 1'b0;
		end else begin
			rx_valid_reg <= 1'b0;
			if (!rx_busy_reg) begin
				if (!rxd_sync_reg) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg <= 32'(BIT_CYC / 2);
					rx_bit_reg <= '0;
				end
			end else if (rx_cnt_reg != 32'h0) begin
				rx_cnt_reg <= rx_cnt_reg - 32'h1;
			end else begin
				rx_cnt_reg <= 32'(BIT_CYC - 1);
				rx_bit_reg <= rx_bit_reg + 4'h1;
				if (rx_bit_reg == 4'h0 && rxd_sync_reg) begin
					// Glitch, not a start bit
					rx_busy_reg <= 1'b0;
				end else if (rx_bit_reg == 4'(STOP_INDEX)) begin
					// one stop bit checked; extra stop time is idle line
					rx_busy_reg <= 1'b0;
					rx_data_reg <= rx_shift_reg;
					rx_valid_reg <= 1'b1;
					rx_stop_err_reg <= !rxd_sync_reg;
				end else if (rx_bit_reg != 4'h0) begin
					rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[7:1]};
				end
			end
		end
	end

	// answer deadline from the closing flag of a request
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			in_frame_reg <= 1'b0;
			armed_reg <= 1'b0;
			answer_cnt_reg <= '0;
			answer_late_reg <= 1'b0;
		end else begin
			if (rx_valid_reg && rx_data_reg == FLAG_BYTE) begin
				in_frame_reg <= !in_frame_reg;
			end
			if (packet_begin) begin
				// Answer under way, deadline met or late flag withdrawn
				armed_reg <= 1'b0;
				answer_late_reg <= 1'b0;
			end else if (rx_valid_reg && rx_data_reg == FLAG_BYTE && in_frame_reg) begin
				armed_reg <= 1'b1;
				answer_cnt_reg <= '0;
			end else if (armed_reg) begin
				if (answer_cnt_reg == 32'(ANSWER_LIMIT_CYC - 1)) begin
					armed_reg <= 1'b0;
					answer_late_reg <= 1'b1;
				end else begin
					answer_cnt_reg <= answer_cnt_reg + 32'h1;
				end
			end
		end
	end

	// Outputs straight from flip-flops
	assign link.mote_txd = txd_reg;
	assign link.mote_request_to_send_n = rts_n_reg;
	assign link.mote_packet_clear_n = pclear_n_reg;
	assign tx_ready = tx_ready_reg;
	assign rx_data = rx_data_reg;
	assign rx_valid = rx_valid_reg;
	assign rx_stop_err = rx_stop_err_reg;
	assign answer_late = answer_late_reg;
	assign ack_timeout = ack_timeout_reg;
endmodule
`default_nettype wire

// *** rtl/uart_link_pkg.sv ***
// Notes on behaviour
// - Host baud within 2%, mote within 1%
// - At 9600 bps both send one stop bit
// - At 115.2 kbps host sends 1.5 stop bits
// - Mote drops request within 10 ms of clear
// - Host grants clear within 500 ms of request
// - After timeout mote retries within 500 ms
// - Mote starts byte within 10 ms of clear
// - Host holds clear one bit after start
// - Host acknowledge pulse lasts at least 500 ns
// - Mote answers each request within 125 ms
// - Host drops clear within 7.1 ms of start
// - Senders wait 20 ms between packets
// - Host sends no repeated leading flag byte
// - Mote requests low until clear or timeout
// - Host acknowledges each byte; mote waits reassertion (the mote skips this wait after a packet's last byte)
// - Packet clear high when unjoined or full
package uart_link_pkg;
	// System clock and line rates
	localparam int CLK_HZ = 125_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;
	localparam int BAUD_FAST = 115_200;
	localparam int BAUD_SLOW = 9_600;
	// Truncated divisor, far inside both baud tolerances
	localparam int BIT_CYC_FAST = CLK_HZ / BAUD_FAST;
	localparam int BIT_CYC_SLOW = CLK_HZ / BAUD_SLOW;
	// Stop length in half bits
	localparam int TX_STOP_HALVES_MOTE = 2;
	localparam int TX_STOP_HALVES_FAST = 3;
	localparam int TX_STOP_HALVES_SLOW = 2;
	// Times as specified
	localparam int CTS_TO_RTS_MS = 10;
	localparam int RTS_TIMEOUT_MS = 500;
	localparam int RETRY_TIME_MS = 500;
	localparam int START_DEADLINE_MS = 10;
	localparam int ACK_PULSE_NS = 500;
	localparam int ANSWER_MS = 125;
	localparam int INTERBYTE_US = 7100;
	localparam int PACKET_GAP_MS = 20;
	// Cycle counts: least times round up, longest round down
	localparam int RTS_TIMEOUT_CYC = RTS_TIMEOUT_MS * CLK_KHZ;
	localparam int RETRY_TIME_CYC = RETRY_TIME_MS * CLK_KHZ;
	localparam int START_DEADLINE_CYC = START_DEADLINE_MS * CLK_KHZ;
	localparam int ACK_PULSE_CYC = (ACK_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int ANSWER_CYC = ANSWER_MS * CLK_KHZ;
	localparam int INTERBYTE_CYC = INTERBYTE_US * (CLK_HZ / 1_000_000);
	localparam int PACKET_GAP_CYC = PACKET_GAP_MS * CLK_KHZ;
	// Frame layout
	localparam int DATA_BITS = 8;
	localparam int STOP_INDEX = DATA_BITS + 1;
	localparam logic [7:0] FLAG_BYTE = 8'h7e;
	// Mote sender states
	typedef enum logic [6:0] {
		MT_IDLE = 7'h01,
		MT_GAP = 7'h02,
		MT_REQ = 7'h04,
		MT_RETRY = 7'h08,
		MT_LOAD = 7'h10,
		MT_SHIFT = 7'h20,
		MT_ACK = 7'h40
	} mote_tx_state_t;
	// Host sender states
	typedef enum logic [2:0] {
		HT_IDLE = 3'h1,
		HT_SHIFT = 3'h2,
		HT_GAP = 3'h4
	} host_tx_state_t;
	// Host clear-to-send states
	typedef enum logic [2:0] {
		HC_OFF = 3'h1,
		HC_ON = 3'h2,
		HC_ACK = 3'h4
	} host_cts_state_t;
endpackage

// *** rtl/uart_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Five-signal link; all handshake lines active low
interface uart_link_if;
	logic mote_txd;                 // Serial data mote to host
	logic host_txd;                 // Serial data host to mote
	logic mote_request_to_send_n;   // Mote has a packet for the host
	logic host_clear_to_send_n;     // Host ready, pulsed high as byte acknowledge
	logic mote_packet_clear_n;      // Mote can take a network packet
	modport device (
		output mote_txd,
		input host_txd,
		output mote_request_to_send_n,
		input host_clear_to_send_n,
		output mote_packet_clear_n
	);
	modport host (
		input mote_txd,
		output host_txd,
		input mote_request_to_send_n,
		output host_clear_to_send_n,
		input mote_packet_clear_n
	);
endinterface
`default_nettype wire

// *** rtl/host_uart_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_uart_end import uart_link_pkg::*; #(
	parameter int BIT_CYC = BIT_CYC_FAST,
	parameter int STOP_HALVES = TX_STOP_HALVES_FAST,
	parameter int ACK_CYC = ACK_PULSE_CYC,
	parameter int LINGER_CYC = 2 * START_DEADLINE_CYC,
	parameter int GAP_CYC = PACKET_GAP_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	uart_link_if.host link,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_last,
	input wire logic tx_net,
	output logic tx_ready,
	input wire logic rx_enable,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_stop_err
);
	// Pin synchronisers
	logic rts_meta_reg, rts_sync_reg;
	logic pclr_meta_reg, pclr_sync_reg;
	logic rxd_meta_reg, rxd_sync_reg;
	// Sender
	host_tx_state_t tx_state_reg;
	logic [31:0] tx_timer_reg;
	logic [8:0] tx_shift_reg;
	logic [3:0] tx_bit_reg;
	logic tx_last_reg, mid_packet_reg, txd_reg, tx_ready_reg;
	// Clear-to-send
	host_cts_state_t cts_state_reg;
	logic [31:0] cts_timer_reg;
	logic cts_n_reg;
	// Receiver
	logic rx_busy_reg;
	logic [31:0] rx_cnt_reg;
	logic [3:0] rx_bit_reg;
	logic [7:0] rx_shift_reg, rx_data_reg;
	logic rx_valid_reg, rx_stop_err_reg;
	logic may_start;

	// network packets start only while the mote reports room
	assign may_start = mid_packet_reg || !tx_net || !pclr_sync_reg;

	// Pins from the mote pass two flops
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rts_meta_reg <= 1'b1;
			rts_sync_reg <= 1'b1;
			pclr_meta_reg <= 1'b1;
			pclr_sync_reg <= 1'b1;
			rxd_meta_reg <= 1'b1;
			rxd_sync_reg <= 1'b1;
		end else begin
			rts_meta_reg <= link.mote_request_to_send_n;
			rts_sync_reg <= rts_meta_reg;
			pclr_meta_reg <= link.mote_packet_clear_n;
			pclr_sync_reg <= pclr_meta_reg;
			rxd_meta_reg <= link.mote_txd;
			rxd_sync_reg <= rxd_meta_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_state_reg <= HT_IDLE;
			tx_timer_reg <= '0;
			tx_shift_reg <= '0;
			tx_bit_reg <= '0;
			tx_last_reg <= 1'b0;
			mid_packet_reg <= 1'b0;
			txd_reg <= 1'b1;
			tx_ready_reg <= 1'b0;
		end else begin
			tx_ready_reg <= 1'b0;
			unique case (tx_state_reg)
				HT_IDLE: begin
					// bytes go out as given, no flag is prepended
					if (tx_valid && may_start) begin
						txd_reg <= 1'b0;
						tx_shift_reg <= {1'b1, tx_data};
						tx_last_reg <= tx_last;
						tx_ready_reg <= 1'b1;
						mid_packet_reg <= !tx_last;
						tx_bit_reg <= '0;
						tx_timer_reg <= '0;
						tx_state_reg <= HT_SHIFT;
					end
				end
				HT_SHIFT: begin
					if (tx_bit_reg == 4'(STOP_INDEX)) begin
						if (tx_timer_reg == 32'(BIT_CYC * STOP_HALVES / 2 - 1)) begin
							tx_timer_reg <= '0;
							tx_state_reg <= tx_last_reg ? HT_GAP : HT_IDLE;
						end else begin
							tx_timer_reg <= tx_timer_reg + 32'h1;
						end
					end else if (tx_timer_reg == 32'(BIT_CYC - 1)) begin
						tx_timer_reg <= '0;
						txd_reg <= tx_shift_reg[0];
						tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
						tx_bit_reg <= tx_bit_reg + 4'h1;
					end else begin
						tx_timer_reg <= tx_timer_reg + 32'h1;
					end
				end
				HT_GAP: begin
					if (tx_timer_reg == 32'(GAP_CYC - 1)) begin
						tx_timer_reg <= '0;
						tx_state_reg <= HT_IDLE;
					end else begin
						tx_timer_reg <= tx_timer_reg + 32'h1;
					end
				end
			endcase
		end
	end

	// Clear-to-send: grant, per-byte acknowledge, release when idle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cts_state_reg <= HC_OFF;
			cts_timer_reg <= '0;
			cts_n_reg <= 1'b1;
		end else begin
			unique case (cts_state_reg)
				HC_OFF: begin
					if (rx_enable && !rts_sync_reg) begin
						cts_n_reg <= 1'b0;
						cts_timer_reg <= '0;
						cts_state_reg <= HC_ON;
					end
				end
				HC_ON: begin
					if (rx_valid_reg) begin
						// negation at the stop sample, well after one bit
						cts_n_reg <= 1'b1;
						cts_timer_reg <= '0;
						cts_state_reg <= HC_ACK;
					end else if (rx_busy_reg) begin
						cts_timer_reg <= '0;
					end else if (cts_timer_reg == 32'(LINGER_CYC - 1)) begin
						// Mote sent nothing more; a limitation is that a new
						// request inside this window is served by this grant
						cts_n_reg <= 1'b1;
						cts_state_reg <= HC_OFF;
					end else begin
						cts_timer_reg <= cts_timer_reg + 32'h1;
					end
				end
				HC_ACK: begin
					// pulse held for the least width
					if (cts_timer_reg == 32'(ACK_CYC - 1)) begin
						cts_n_reg <= 1'b0;
						cts_timer_reg <= '0;
						cts_state_reg <= HC_ON;
					end else begin
						cts_timer_reg <= cts_timer_reg + 32'h1;
					end
				end
			endcase
		end
	end

	// Receiver, mid-bit sampling
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_busy_reg <= 1'b0;
			rx_cnt_reg <= '0;
			rx_bit_reg <= '0;
			rx_shift_reg <= '0;
			rx_data_reg <= '0;
			rx_valid_reg <= 1'b0;
			rx_stop_err_reg <= 1'b0;
		end else begin
			rx_valid_reg <= 1'b0;
			if (!rx_busy_reg) begin
				if (!rxd_sync_reg) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg <= 32'(BIT_CYC / 2);
					rx_bit_reg <= '0;
				end
			end else if (rx_cnt_reg != 32'h0) begin
				rx_cnt_reg <= rx_cnt_reg - 32'h1;
			end else begin
				rx_cnt_reg <= 32'(BIT_CYC - 1);
				rx_bit_reg <= rx_bit_reg + 4'h1;
				if (rx_bit_reg == 4'h0 && rxd_sync_reg) begin
					rx_busy_reg <= 1'b0;
				end else if (rx_bit_reg == 4'(STOP_INDEX)) begin
					rx_busy_reg <= 1'b0;
					rx_data_reg <= rx_shift_reg;
					rx_valid_reg <= 1'b1;
					rx_stop_err_reg <= !rxd_sync_reg;
				end else if (rx_bit_reg != 4'h0) begin
					rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[7:1]};
				end
			end
		end
	end

	// Outputs straight from flip-flops
	assign link.host_txd = txd_reg;
	assign link.host_clear_to_send_n = cts_n_reg;
	assign tx_ready = tx_ready_reg;
	assign rx_data = rx_data_reg;
	assign rx_valid = rx_valid_reg;
	assign rx_stop_err = rx_stop_err_reg;
endmodule
`default_nettype wire

// *** verif/uart_link_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_link_chk #(
	parameter int BIT_CYC = 16,
	parameter int RTS_WAIT_CYC = 200,
	parameter int RETRY_CYC = 100,
	parameter int INTERBYTE_LIMIT_CYC = 400
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic mote_txd,
	input wire logic host_txd,
	input wire logic mote_request_to_send_n,
	input wire logic host_clear_to_send_n,
	input wire logic mote_packet_clear_n
);
	// Slack on the retry wait covers the synchroniser and state hops
	localparam int RETRY_MAX = RETRY_CYC + 4;
	localparam int MOTE_LEN = 10 * BIT_CYC;
	// Host frames carry one and a half stop bits
	localparam int HOST_LEN = 10 * BIT_CYC + BIT_CYC / 2;
	int m_pos; // Cycle inside the mote frame, zero when idle
	int h_pos; // Cycle inside the host frame, zero when idle
	int req_low; // Cycles the request has been low
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Track mote frames from the start edge
	always_ff @(posedge clk_sys) begin
		if (srst || m_pos == MOTE_LEN - 1) begin
			m_pos <= 0;
		end else if (m_pos != 0 || !mote_txd) begin
			m_pos <= m_pos + 1;
		end
	end
	// Track host frames the same way
	always_ff @(posedge clk_sys) begin
		if (srst || h_pos == HOST_LEN - 1) begin
			h_pos <= 0;
		end else if (h_pos != 0 || !host_txd) begin
			h_pos <= h_pos + 1;
		end
	end
	// Length of the present request
	always_ff @(posedge clk_sys) begin
		if (srst || mote_request_to_send_n) begin
			req_low <= 0;
		end else begin
			req_low <= req_low + 1;
		end
	end
	sequence mote_start;
		m_pos == 0 && $fell(mote_txd);
	endsequence
	sequence ack_rise;
		$rose(host_clear_to_send_n);
	endsequence
	a_mote_stop: assert property (m_pos > 9 * BIT_CYC |-> mote_txd)
		else $error("mote stop bit low");
	a_host_stop: assert property (h_pos > 9 * BIT_CYC |-> host_txd)
		else $error("host stop interval short");
	a_request_drop: assert property ($fell(host_clear_to_send_n) && !mote_request_to_send_n
		|-> ##[1:5] mote_request_to_send_n) else $error("request not dropped after clear");
	a_request_limit: assert property (req_low <= RTS_WAIT_CYC + 1)
		else $error("request held past timeout");
	a_retry_bound: assert property ($rose(mote_request_to_send_n) && host_clear_to_send_n
		&& $past(host_clear_to_send_n, 3) |-> ##[1:RETRY_MAX] !mote_request_to_send_n)
		else $error("no retry after timeout");
	a_start_prompt: assert property ($rose(mote_request_to_send_n) && !host_clear_to_send_n
		|-> ##[1:3] !mote_txd) else $error("start bit late after clear");
	a_clear_held: assert property (m_pos >= 1 && m_pos <= BIT_CYC |-> !host_clear_to_send_n)
		else $error("clear dropped inside first bit");
	// Acknowledge pulse of three cycles in the shortened run
	a_ack_width: assert property (ack_rise |-> host_clear_to_send_n[*3])
		else $error("acknowledge pulse too short");
	a_ack_deadline: assert property (mote_start |-> ##[1:INTERBYTE_LIMIT_CYC] ack_rise)
		else $error("no acknowledge after byte");
	a_wait_clear: assert property (mote_start |-> !$past(host_clear_to_send_n, 1)
		&& !$past(host_clear_to_send_n, 2)) else $error("byte started without clear");
	a_clear_reset: assert property ($past(srst) |-> mote_packet_clear_n)
		else $error("packet clear low after reset");
endmodule
`default_nettype wire

// *** verif/mote_uart_handshake_timing_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module mote_uart_handshake_timing_test;
	localparam int BC = 16; // Shortened bit time
	// Shortened waits, in a different order from the real ones
	localparam int RTS_W = 200;
	localparam int RETRY_W = 100;
	localparam int ANSWER_W = 2000;
	localparam int IBYTE_W = 400;
	localparam int GAP_W = 50;
	localparam int HALVES = 3;
	localparam int ACK_W = 3;
	localparam int LINGER_W = 300;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [7:0] m_td = 8'h00, h_td = 8'h00;
	logic m_tv = 1'b0, m_tl = 1'b0, h_tv = 1'b0, h_tl = 1'b0, h_net = 1'b0;
	logic rx_en = 1'b0, joined = 1'b0, bfree = 1'b0;
	logic m_rdy, m_rv, m_re, h_rdy, h_rv, h_re, late, ack_to;
	logic [7:0] m_rd, h_rd;
	logic [8:0] mq[$], hq[$]; // Received bytes, stop error on top
	int fail_count = 0, tests_run = 0;
	int n;
	uart_link_if link ();
	mote_uart_end #(.BIT_CYC(BC), .RTS_WAIT_CYC(RTS_W), .RETRY_CYC(RETRY_W),
		.ANSWER_LIMIT_CYC(ANSWER_W), .INTERBYTE_LIMIT_CYC(IBYTE_W), .GAP_CYC(GAP_W))
		i_mote_uart_end (.clk_sys(clk_sys),
		.srst(srst), .link(link), .tx_data(m_td), .tx_valid(m_tv), .tx_last(m_tl),
		.tx_ready(m_rdy), .rx_data(m_rd), .rx_valid(m_rv), .rx_stop_err(m_re),
		.net_joined(joined), .buf_free(bfree), .answer_late(late), .ack_timeout(ack_to));
	host_uart_end #(.BIT_CYC(BC), .STOP_HALVES(HALVES), .ACK_CYC(ACK_W),
		.LINGER_CYC(LINGER_W), .GAP_CYC(GAP_W)) i_host_uart_end (.clk_sys(clk_sys),
		.srst(srst), .link(link),
		.tx_data(h_td), .tx_valid(h_tv), .tx_last(h_tl), .tx_net(h_net), .tx_ready(h_rdy),
		.rx_enable(rx_en), .rx_data(h_rd), .rx_valid(h_rv), .rx_stop_err(h_re));
	uart_link_chk #(.BIT_CYC(BC), .RTS_WAIT_CYC(RTS_W), .RETRY_CYC(RETRY_W),
		.INTERBYTE_LIMIT_CYC(IBYTE_W)) i_uart_link_chk (.clk_sys(clk_sys), .srst(srst),
		.mote_txd(link.mote_txd), .host_txd(link.host_txd),
		.mote_request_to_send_n(link.mote_request_to_send_n),
		.host_clear_to_send_n(link.host_clear_to_send_n),
		.mote_packet_clear_n(link.mote_packet_clear_n));
	// Free running system clock
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	// Collect what each end receives
	always @(posedge clk_sys) begin
		if (m_rv === 1'b1) mq.push_back({m_re, m_rd});
		if (h_rv === 1'b1) hq.push_back({h_re, h_rd});
	end
	// Inputs always move one nanosecond after the edge
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	// Offer a byte at one end and hold it until taken
	task automatic put(input bit to_host, input logic [7:0] d, input logic l);
		int k;
		if (to_host) {m_td, m_tl, m_tv} = {d, l, 1'b1};
		else {h_td, h_tl, h_tv} = {d, l, 1'b1};
		for (k = 0; k < 9000 && (to_host ? m_rdy : h_rdy) !== 1'b1; k++) cyc(1);
		`CHK("taken", 1'b1, to_host ? m_rdy : h_rdy)
		// Valid drops for a cycle so a following call never retoggles it in one step
		if (to_host) m_tv = 1'b0;
		else h_tv = 1'b0;
		cyc(1);
	endtask
	// Wait for the bytes at one end, then compare in order
	task automatic check_rx(input bit at_host, input logic [7:0] e[$]);
		int k;
		for (k = 0; k < 3000 && (at_host ? hq.size() : mq.size()) < e.size(); k++) cyc(1);
		`CHK("rx_count", e.size(), at_host ? hq.size() : mq.size())
		foreach (e[i]) `CHK("rx", {1'b0, e[i]}, at_host ? hq[i] : mq[i])
		hq.delete();
		mq.delete();
	endtask
	task automatic t_idle();
		`CHK("pins", 5'h1f, {link.mote_txd, link.host_txd, link.mote_request_to_send_n,
			link.host_clear_to_send_n, link.mote_packet_clear_n})
	endtask
	// local request, then the mote stays silent too long
	task automatic t_late();
		put(0, 8'h7e, 1'b0);
		put(0, 8'h3c, 1'b0);
		put(0, 8'h7e, 1'b1);
		check_rx(0, '{8'h7e, 8'h3c, 8'h7e});
		cyc(ANSWER_W - 100);
		`CHK("late_early", 1'b0, late)
		cyc(200);
		`CHK("late", 1'b1, late)
	endtask
	task automatic t_mote_pkt();
		rx_en = 1'b1;
		put(1, 8'h7e, 1'b0);
		put(1, 8'ha5, 1'b0);
		put(1, 8'h7e, 1'b1);
		check_rx(1, '{8'h7e, 8'ha5, 8'h7e});
		`CHK("late_clear", 1'b0, late)
		`CHK("ack_timeout", 1'b0, ack_to)
	endtask
	// network packet held back until the mote can take it
	task automatic t_gate();
		{h_td, h_tl, h_net, h_tv} = {8'h7e, 1'b0, 1'b1, 1'b1};
		cyc(100);
		`CHK("gated", 1'b1, link.host_txd)
		{joined, bfree} = 2'b11;
		cyc(4);
		`CHK("pkt_clear", 1'b0, link.mote_packet_clear_n)
		put(0, 8'h7e, 1'b0);
		h_net = 1'b0;
		put(0, 8'h5a, 1'b0);
		put(0, 8'h7e, 1'b1);
		check_rx(0, '{8'h7e, 8'h5a, 8'h7e});
		bfree = 1'b0;
		cyc(4);
		`CHK("pkt_full", 1'b1, link.mote_packet_clear_n)
	endtask
	// host refuses, mote times out and retries
	task automatic t_retry();
		rx_en = 1'b0;
		cyc(400);
		{m_td, m_tl, m_tv} = {8'hc3, 1'b1, 1'b1};
		for (n = 0; n < 1000 && link.mote_request_to_send_n !== 1'b0; n++) cyc(1);
		for (n = 0; n < 1000 && link.mote_request_to_send_n === 1'b0; n++) cyc(1);
		`CHK("req_low", 1'b1, n >= RTS_W - 3 && n <= RTS_W + 3)
		for (n = 0; n < 1000 && link.mote_request_to_send_n !== 1'b0; n++) cyc(1);
		`CHK("retry_gap", 1'b1, n >= RETRY_W - 3 && n <= RETRY_W + 3)
		rx_en = 1'b1;
		put(1, 8'hc3, 1'b1);
		check_rx(1, '{8'hc3});
	endtask
	// Verdict and end of run
	task automatic stop_test();
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		cyc(3);
		srst = 1'b0;
		cyc(2);
		t_idle();
		t_late();
		t_mote_pkt();
		t_gate();
		t_retry();
		stop_test();
	end
	// Cut a hang short well past the expected run
	initial begin
		#400000;
		fail_count++;
		stop_test();
	end
endmodule
`default_nettype wire
